// [core/haptic_rtp_defines.vh]
`ifndef HAPTIC_RTP_DEFINES_VH
`define HAPTIC_RTP_DEFINES_VH

// ==========================================
// Register offsets
`define ADDR_REALTIME_AMPLITUDE   8'h02
`define ADDR_LIBRARY_CONTROL      8'h03

// ==========================================
// Reset values
`define RST_REALTIME_AMPLITUDE    8'h00
`define RST_LIBRARY_SEL           3'h1
`define RST_OUTPUT_FLOAT          1'b0
`define RST_STANDBY               1'b1
`define RST_MODE                  3'h0

// ==========================================
// Field positions
`define LIB_OUTPUT_FLOAT_BIT      4
`define LIB_SEL_MSB               2
`define LIB_SEL_LSB               0

// ==========================================
// Operating modes and library codes
`define MODE_INTERNAL_TRIGGER     3'h0
`define MODE_REALTIME_PLAYBACK    3'h5
`define LIB_EMPTY                 3'h0
`define LIB_LINEAR_RESONANT       3'h6
`define LIB_RESERVED              3'h7

// ==========================================
// Buffering
`define AMP_FIFO_WIDTH            8
`define AMP_FIFO_DEPTH            32
`define AMP_FIFO_AW               5

`endif

// [core/amp_fifo_mem.v]
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Storage for the amplitude FIFO, registered read
module amp_fifo_mem #(
    parameter WIDTH = 8,
    parameter AW    = 5
) (
    input  wire             sys_clk_i,
    input  wire             wr_en_i,
    input  wire [AW-1:0]    wr_addr_i,
    input  wire [WIDTH-1:0] wr_data_i,
    input  wire [AW-1:0]    rd_addr_i,
    output reg  [WIDTH-1:0] rd_data_o
);

    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    always @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule

`default_nettype wire

// [core/amp_fifo.v]
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Show-ahead FIFO with valid/ready on both sides
module amp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             sys_clk_i,
    input  wire             nrst_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o,
    output wire             full_o,
    output wire             empty_o
);

    reg  [AW:0]      wr_ptr_q;
    reg  [AW:0]      rd_ptr_q;
    reg              out_valid_q;
    wire [AW:0]      count;
    wire             push;
    wire             pop;
    wire             load;
    wire [AW-1:0]    rd_addr;
    wire [WIDTH-1:0] mem_q;

    assign count       = wr_ptr_q - rd_ptr_q;
    // Held output word keeps its slot until popped
    assign full_o      = (count == (DEPTH[AW:0] - {{AW{1'b0}}, out_valid_q}));
    assign empty_o     = (count == {(AW+1){1'b0}});
    assign in_ready_o  = ~full_o;
    assign push        = in_valid_i & ~full_o;
    assign pop         = out_valid_q & out_ready_i;
    // Reload the output word when it is consumed or absent
    assign load        = ~empty_o & (~out_valid_q | pop);
    // Re-read the held word unless a new one is loaded
    assign rd_addr     = load ? rd_ptr_q[AW-1:0]
                              : (rd_ptr_q[AW-1:0] - {{(AW-1){1'b0}}, 1'b1});
    assign out_valid_o = out_valid_q;
    assign out_data_o  = mem_q;

    amp_fifo_mem #(.WIDTH(WIDTH), .AW(AW)) u_mem (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (push),
        .wr_addr_i (wr_ptr_q[AW-1:0]),
        .wr_data_i (in_data_i),
        .rd_addr_i (rd_addr),
        .rd_data_o (mem_q)
    );

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_q    <= {(AW+1){1'b0}};
            rd_ptr_q    <= {(AW+1){1'b0}};
            out_valid_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (load) begin
                rd_ptr_q    <= rd_ptr_q + 1'b1;
                out_valid_q <= 1'b1;
            end else if (pop) begin
                out_valid_q <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// [core/haptic_rtp_and_library_control.v]
`timescale 1ns/100ps
`default_nettype none
`include "haptic_rtp_defines.vh"

module haptic_rtp_and_library_control (
    input  wire       sys_clk_i,
    input  wire       nrst_i,
    input  wire       hw_enable_i,
    input  wire       reg_wr_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    input  wire [2:0] mode_i,
    input  wire       standby_i,
    input  wire       amplitude_sign_select_i,
    input  wire       fire_i,
    input  wire       fire_done_i,
    output wire       fire_o,
    output reg  [2:0] active_library_o,
    output wire       library_valid_o,
    output reg  [8:0] drive_level_o,
    output wire       drive_active_o,
    output wire       output_float_o,
    output wire       output_pulldown_o,
    output wire       amp_fifo_full_o,
    input  wire       drive_ready_i
);

    // ==========================================
    // Two-flop input synchroniser for the hw_enable_i pin only
    reg  [1:0] en_sync_q;
    wire       enabled;

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_sync_q <= 2'b00;
        end else begin
            en_sync_q <= {en_sync_q[0], hw_enable_i};
        end
    end
    assign enabled = en_sync_q[1];

    // ==========================================
    // Register file
    reg  [7:0] realtime_amplitude_q;
    reg  [2:0] library_sel_q;
    reg        output_float_q;
    wire       wr_amp;
    wire       wr_lib;

    assign wr_amp = reg_wr_i & (reg_addr_i == `ADDR_REALTIME_AMPLITUDE);
    assign wr_lib = reg_wr_i & (reg_addr_i == `ADDR_LIBRARY_CONTROL);

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            realtime_amplitude_q <= `RST_REALTIME_AMPLITUDE;
            library_sel_q        <= `RST_LIBRARY_SEL;
            output_float_q       <= `RST_OUTPUT_FLOAT;
        end else begin
            if (wr_amp) begin
                realtime_amplitude_q <= reg_wdata_i;
            end
            if (wr_lib) begin
                library_sel_q  <= reg_wdata_i[`LIB_SEL_MSB:`LIB_SEL_LSB];
                output_float_q <= reg_wdata_i[`LIB_OUTPUT_FLOAT_BIT];
            end
        end
    end

    always @* begin
        case (reg_addr_i)
            `ADDR_REALTIME_AMPLITUDE: reg_rdata_o = realtime_amplitude_q;
            `ADDR_LIBRARY_CONTROL:    reg_rdata_o = {3'h0, output_float_q, 1'b0, library_sel_q};
            default:                  reg_rdata_o = 8'h00;
        endcase
    end

    // ==========================================
    // Mode decode
    wire realtime_playback_mode;
    wire device_ready;

    assign device_ready = enabled & ~standby_i;
    assign realtime_playback_mode     = (mode_i == `MODE_REALTIME_PLAYBACK) & device_ready;

    // ==========================================
    // Amplitude stream buffer: amplitude writes are queued while in playback, dropped when full
    wire       fifo_in_valid;
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire       fifo_pop;

    assign fifo_in_valid   = wr_amp & realtime_playback_mode;
    assign fifo_pop        = drive_ready_i | ~realtime_playback_mode;
    assign amp_fifo_full_o = ~fifo_in_ready;

    amp_fifo #(
        .WIDTH(`AMP_FIFO_WIDTH),
        .DEPTH(`AMP_FIFO_DEPTH),
        .AW   (`AMP_FIFO_AW)
    ) u_amp_fifo (
        .sys_clk_i   (sys_clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (reg_wdata_i),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_out_data),
        .full_o      (),
        .empty_o     ()
    );

    // ==========================================
    // Drive level: signed or unsigned to 9-bit signed
    reg  [7:0] amp_cur_q;
    wire [8:0] amp_ext;

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            amp_cur_q <= `RST_REALTIME_AMPLITUDE;
        end else if (fifo_out_valid & fifo_pop & realtime_playback_mode) begin
            amp_cur_q <= fifo_out_data;
        end
    end

    assign amp_ext = amplitude_sign_select_i ? {1'b0, amp_cur_q}
                                             : {amp_cur_q[7], amp_cur_q};

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            drive_level_o <= 9'h000;
        end else if (realtime_playback_mode) begin
            drive_level_o <= amp_ext;
        end else begin
            drive_level_o <= 9'h000;
        end
    end

    // ==========================================
    // Fire handling and library latch
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_PLAY = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;
    reg [2:0] state_q;
    reg [2:0] state_d;

    always @* begin
        case (state_q)
            ST_IDLE: state_d = (fire_i & device_ready & ~realtime_playback_mode) ? ST_PLAY : ST_IDLE;
            ST_PLAY: begin
                if (!fire_i || !device_ready) begin
                    state_d = ST_IDLE;
                end else if (fire_done_i) begin
                    state_d = ST_DONE;
                end else begin
                    state_d = ST_PLAY;
                end
            end
            ST_DONE: state_d = fire_i ? ST_DONE : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q          <= ST_IDLE;
            active_library_o <= `LIB_EMPTY;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && state_d == ST_PLAY) begin
                active_library_o <= library_sel_q;
            end
        end
    end

    // Fire stays set while playing, cleared by hardware when done
    assign fire_o          = (state_q == ST_PLAY);
    assign library_valid_o = (active_library_o != `LIB_EMPTY)
                           & (active_library_o != `LIB_RESERVED);

    // ==========================================
    // Output stage control, combinational so float acts at once
    assign output_float_o    = output_float_q & device_ready;
    assign output_pulldown_o = ~device_ready;
    assign drive_active_o    = device_ready & ~output_float_q
                             & (realtime_playback_mode | fire_o);

endmodule

`default_nettype wire

// [verification/haptic_rtp_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checker
module haptic_rtp_chk (
    input wire logic       sys_clk_i,
    input wire logic       nrst_i,
    input wire logic       hw_enable_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [2:0] mode_i,
    input wire logic       standby_i,
    input wire logic       fire_i,
    input wire logic       fire_done_i,
    input wire logic       fire_o,
    input wire logic [2:0] active_library_o,
    input wire logic       library_valid_o,
    input wire logic [8:0] drive_level_o,
    input wire logic       output_float_o,
    input wire logic       output_pulldown_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_float_needs_ready: assert property (output_float_o |-> !standby_i && !output_pulldown_o)
        else $error("float while not ready");
    a_standby_pulls_low: assert property (standby_i |-> output_pulldown_o && !output_float_o)
        else $error("standby without pulldown");
    a_float_at_once: assert property ((reg_wr_i && reg_addr_i == 8'h03 && reg_wdata_i[4] && hw_enable_i
        && $past(hw_enable_i) && $past(nrst_i, 2)) ##1 !standby_i |-> output_float_o)
        else $error("float late");
    a_idle_drive_zero: assert property ((mode_i != 3'h5) |=> drive_level_o == 9'h000)
        else $error("drive outside realtime mode");
    a_fire_cancel: assert property (fire_o && !fire_i |=> !fire_o)
        else $error("cancel ignored");
    a_fire_done_ends: assert property (fire_o && fire_done_i |=> !fire_o)
        else $error("fire not cleared");
    a_fire_needs_bit: assert property ($rose(fire_o) |-> $past(fire_i) && $past(mode_i) != 3'h5)
        else $error("fire without request");
    a_lib_invalid_codes: assert property (active_library_o == 3'h0 || active_library_o == 3'h7
        |-> !library_valid_o)
        else $error("bad library valid");
    a_lib_held_fire: assert property (fire_o && $past(fire_o) |-> $stable(active_library_o))
        else $error("library moved in playback");
    a_reserved_read_zero: assert property (reg_addr_i == 8'h03 |-> reg_rdata_o[7:5] == 3'h0 && !reg_rdata_o[3])
        else $error("reserved bits set");
endmodule
bind haptic_rtp_and_library_control haptic_rtp_chk u_chk (.*);
`default_nettype wire

// [verification/amp_sink_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Output stage: stall, prompt or every fourth cycle
module amp_sink_model (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic [1:0] pace_i,
    output var  logic       drive_ready_o
);
    logic [1:0] cnt_q;
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q         <= 2'h0;
            drive_ready_o <= 1'b0;
        end else begin
            cnt_q         <= cnt_q + 2'h1;
            drive_ready_o <= (pace_i == 2'h1) || (pace_i == 2'h2 && cnt_q == 2'h3);
        end
    end
endmodule
`default_nettype wire

// [verification/haptic_rtp_and_library_control_test.sv]
`timescale 1ns/100ps
`default_nettype none
module haptic_rtp_and_library_control_test;
    logic       sys_clk_i = 0, nrst_i = 0, hw_enable_i = 1, reg_wr_i = 0, standby_i = 1;
    logic       amplitude_sign_select_i = 0, fire_i = 0, fire_done_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, last_v = 8'h00;
    logic [2:0] mode_i = 3'h0;
    logic [1:0] pace = 2'h1;
    logic [7:0] reg_rdata_o;
    logic [2:0] active_library_o;
    logic [8:0] drive_level_o, prev_lvl = 9'h000;
    logic       fire_o, library_valid_o, drive_active_o, output_float_o;
    logic       output_pulldown_o, amp_fifo_full_o, drive_ready_i;
    logic [31:0] lfsr = 32'h39bb;
    logic [8:0] exp_q[$];
    int         n_mismatch = 0, checks_done = 0;
    haptic_rtp_and_library_control uut (.*);
    amp_sink_model u_sink (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pace_i(pace), .drive_ready_o(drive_ready_i));
    always #12.5 sys_clk_i = ~sys_clk_i;
    // ==========================================
    // Helpers
    task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task finish_test;
        if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        cyc(1);
        reg_wr_i = 0;
        cyc(1);
    endtask
    task rd(input logic [7:0] a, input logic [8:0] e);
        reg_addr_i = a;
        #1;
        chk("rdata", {1'b0, reg_rdata_o}, e);
    endtask
    task stream(input logic s, input int n);
        logic [7:0] v;
        amplitude_sign_select_i = s;
        cyc(3);
        for (int i = 0; i < n; i++) begin
            lfsr = lfsr_next(lfsr);
            v = (lfsr[7:0] == last_v) ? ~lfsr[7:0] : lfsr[7:0];
            last_v = v;
            if (amp_fifo_full_o !== 1'b1) exp_q.push_back(s ? {1'b0, v} : {v[7], v});
            reg_addr_i = 8'h02;
            reg_wdata_i = v;
            reg_wr_i = 1;
            cyc(1);
        end
        reg_wr_i = 0;
    endtask
    // ==========================================
    // Drive watcher
    always @(negedge sys_clk_i) begin
        if (drive_level_o !== prev_lvl) begin
            prev_lvl = drive_level_o;
            if (exp_q.size() > 0) chk("drive", drive_level_o, exp_q.pop_front());
        end
    end
    initial begin
        #75000;
        n_mismatch++;
        finish_test;
    end
    // ==========================================
    // Scenarios
    initial begin
        cyc(12);
        nrst_i = 1;
        rd(8'h02, 9'h000);
        rd(8'h03, 9'h001);
        rd(8'h07, 9'h000);
        chk("pulldown", output_pulldown_o, 1);
        wr(8'h03, 8'hff);
        rd(8'h03, 9'h017);
        standby_i = 0;
        cyc(3);
        chk("float", output_float_o, 1);
        standby_i = 1;
        #1 chk("float", {output_float_o, output_pulldown_o}, 2'b01);
        standby_i = 0;
        hw_enable_i = 0;
        cyc(3);
        chk("float", {output_float_o, output_pulldown_o}, 2'b01);
        hw_enable_i = 1;
        cyc(3);
        for (int l = 0; l < 8; l++) begin
            wr(8'h03, 8'(l));
            fire_i = 1;
            cyc(2);
            chk("fire", fire_o, 1);
            wr(8'h03, 8'(l ^ 1));
            chk("lib", active_library_o, 9'(l));
            chk("valid", library_valid_o, l >= 1 && l <= 6);
            if (l == 3) fire_i = 0;
            else fire_done_i = 1;
            cyc(1);
            fire_done_i = 0;
            chk("fire", fire_o, 0);
            fire_i = 0;
            cyc(1);
        end
        fire_i = 1;
        cyc(2);
        wr(8'h03, 8'h13);
        chk("float", {output_float_o, fire_o}, 2'b11);
        fire_i = 0;
        wr(8'h03, 8'h01);
        mode_i = 3'h5;
        stream(0, 20);
        cyc(10);
        chk("queue", 9'(exp_q.size()), 0);
        pace = 2'h0;
        stream(1, 40);
        chk("full", amp_fifo_full_o, 1);
        rd(8'h02, {1'b0, last_v});
        pace = 2'h2;
        cyc(200);
        chk("queue", 9'(exp_q.size()), 0);
        chk("active", drive_active_o, 1);
        standby_i = 1;
        cyc(2);
        chk("active", drive_active_o, 0);
        standby_i = 0;
        mode_i = 3'h0;
        cyc(2);
        chk("drive", {drive_active_o, drive_level_o[7:0]}, 9'h000);
        finish_test;
    end
endmodule
`default_nettype wire
